//--- hdl/uebc_consts.svh
// Constants for the endpoint remaining-byte counter block.
`ifndef UEBC_CONSTS_SVH
`define UEBC_CONSTS_SVH
// =====================================================================
// Sizes
`define UEBC_NUM_EP 4
`define UEBC_EP_IDX_W 2
`define UEBC_CNT_W 10
`define UEBC_BYTES_PER_READ 10'h004
// =====================================================================
// Register offsets (byte addresses, word index in address bits [5:2])
`define UEBC_ADDR_W 8
`define UEBC_OFF_COUNT_BASE 8'h00
`define UEBC_OFF_CSR_BASE 8'h10
`define UEBC_OFF_CFG 8'h20
`define UEBC_OFF_IRQ_STAT 8'h24
`define UEBC_OFF_IRQ_MASK 8'h28
// =====================================================================
// Control/status field positions
`define UEBC_CSR_FS 0
`define UEBC_CSR_PC 1
`define UEBC_CSR_DME 3
`define UEBC_CSR_BNE 6
// Configuration field positions, per endpoint in a nibble.
`define UEBC_CFG_DIR_IN 0
`define UEBC_CFG_DBUF 1
`define UEBC_CFG_NIB 4
`define UEBC_RESET_WORD 32'h0000_0000
`endif

//--- hdl/uebc_pkg.sv
// Types for the endpoint remaining-byte counter block.
`include "uebc_consts.svh"
package uebc_pkg;
  // Slot of one receive buffer.
  typedef struct packed {
    logic full;
    logic [`UEBC_CNT_W-1:0] len;
  } uebc_slot_s;
  // Packet handed in by the link logic.
  typedef struct packed {
    logic valid;
    logic [`UEBC_EP_IDX_W-1:0] ep;
    logic [`UEBC_CNT_W-1:0] len;
  } uebc_pkt_s;
  // Avalon-MM request.
  typedef struct packed {
    logic read;
    logic write;
    logic [`UEBC_ADDR_W-1:0] address;
    logic [31:0] writedata;
  } uebc_avm_req_s;
  // Per endpoint state.
  typedef struct packed {
    logic [`UEBC_CNT_W-1:0] count;
    logic second_active;
    logic pc;
    logic bne;
    logic dma_enable;
    uebc_slot_s pend;
  } uebc_ep_s;
  typedef enum logic [1:0] {
    UEBC_BUS_IDLE = 2'b00,
    UEBC_BUS_ACK = 2'b01
  } uebc_bus_e;
endpackage

//--- hdl/uebc_ep_counter.sv
// One endpoint's remaining-byte counter and buffer flags.
`timescale 1ns/1ps
`include "uebc_consts.svh"
module uebc_ep_counter (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic is_in,
  input wire logic dbuf,
  input wire logic pkt_in,
  input wire logic [`UEBC_CNT_W-1:0] pkt_len,
  input wire logic fifo_rd,
  input wire logic pc_clr,
  input wire logic dme_wr,
  input wire logic dme_val,
  output uebc_pkg::uebc_ep_s st,
  output logic fifo_service,
  output logic overrun,
  output logic pkt_event
);
  import uebc_pkg::*;
  uebc_ep_s s_q;
  uebc_ep_s s_d;
  logic empty_now;

  // =====================================================================
  // Next-state logic
  // A read of an empty buffer never advances into the pending one.
  always_comb begin
    s_d = s_q;
    overrun = 1'b0;
    pkt_event = 1'b0;
    empty_now = 1'b0;
    if (dme_wr) begin
      s_d.dma_enable = dme_val;
    end
    if (fifo_rd && !is_in) begin
      if (s_q.count == '0) begin
        overrun = 1'b1;
      end else if (s_q.count <= `UEBC_BYTES_PER_READ) begin
        s_d.count = '0;
        empty_now = 1'b1;
      end else begin
        s_d.count = s_q.count - `UEBC_BYTES_PER_READ;
      end
    end
    // Buffer-not-empty falls together with the count reaching zero.
    if (empty_now || (s_q.count == '0 && !s_q.pc)) begin
      s_d.bne = 1'b0;
    end
    if (pc_clr && s_q.pc) begin
      s_d.pc = 1'b0;
      if (s_q.pend.full) begin
        // Second buffer becomes active only once software clears PC.
        s_d.count = s_q.pend.len;
        s_d.bne = dbuf ? 1'b1 : (s_q.pend.len != '0);
        s_d.second_active = 1'b1;
        s_d.pc = 1'b1;
        s_d.pend.full = 1'b0;
        pkt_event = 1'b1;
      end else begin
        s_d.second_active = 1'b0;
        s_d.bne = 1'b0;
      end
    end
    if (pkt_in && !is_in) begin
      // Judge against this cycle's clear as well: a packet that parked while
      // packet-complete drops would never be loaded.
      if (!s_d.pc && !s_d.pend.full) begin
        // Load the count in the same cycle that the packet is flagged to software.
        s_d.count = pkt_len;
        s_d.pc = 1'b1;
        s_d.bne = dbuf ? 1'b0 : (pkt_len != '0);
        s_d.second_active = 1'b0;
        pkt_event = 1'b1;
      end else begin
        // Held until PC is cleared; the visible count is untouched.
        s_d.pend.full = 1'b1;
        s_d.pend.len = pkt_len;
      end
    end
  end

  // =====================================================================
  // State register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign st = s_q;
  // FIFO service stays set while either buffer still holds data.
  assign fifo_service = !is_in && ((s_q.count != '0) || s_q.pend.full);
endmodule

//--- hdl/uebc_irq.sv
// Sticky interrupt status with a write-one-to-clear and a mask.
`timescale 1ns/1ps
`include "uebc_consts.svh"
module uebc_irq (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [`UEBC_NUM_EP*2-1:0] events,
  input wire logic clr_wr,
  input wire logic mask_wr,
  input wire logic [31:0] wdata,
  output logic [`UEBC_NUM_EP*2-1:0] status,
  output logic [`UEBC_NUM_EP*2-1:0] mask,
  output logic irq
);
  import uebc_pkg::*;
  typedef struct packed {
    logic [`UEBC_NUM_EP*2-1:0] stat;
    logic [`UEBC_NUM_EP*2-1:0] msk;
  } uebc_irq_s;
  uebc_irq_s r_q;
  uebc_irq_s r_d;

  // =====================================================================
  // A new event wins over a clear in the same cycle.
  always_comb begin
    r_d = r_q;
    if (clr_wr) begin
      r_d.stat = r_q.stat & ~wdata[`UEBC_NUM_EP*2-1:0];
    end
    if (mask_wr) begin
      r_d.msk = wdata[`UEBC_NUM_EP*2-1:0];
    end
    r_d.stat = r_d.stat | events;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign status = r_q.stat;
  assign mask = r_q.msk;
  assign irq = |(r_q.stat & r_q.msk);
endmodule

//--- hdl/uebc_top.sv
// Remaining-byte counters for the receive endpoints of a USB device controller.
// Function
// - Keep a remaining-byte count for control and every Out endpoint.
// - Each endpoint has a count register; In endpoints read it as reserved zero.
// - Single buffering: count drops with each read, zero when buffer empty.
// - Single buffering: clear buffer-not-empty once the count reaches zero.
// - Double buffering: count tracks only the active buffer, drops per read.
// - Active buffer empty but second holds data: keep fifo-service set.
// - Double buffering: not-empty flag set on second buffer, zero on first.
// - Reads past zero give undefined data and never enter the second buffer.
// - Clearing packet-complete loads second count, sets flag, enables its data.
// - Setup after Status: count shows Setup length before out-complete cleared.
`timescale 1ns/1ps
`include "uebc_consts.svh"
module uebc_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire uebc_pkg::uebc_avm_req_s avs_req,
  output logic avs_waitrequest,
  output logic [31:0] avs_readdata,
  input wire uebc_pkg::uebc_pkt_s rx_pkt,
  input wire logic fifo_rd,
  input wire logic [`UEBC_EP_IDX_W-1:0] fifo_rd_ep,
  output logic [`UEBC_NUM_EP-1:0] fifo_service,
  output logic irq
);
  import uebc_pkg::*;

  typedef struct packed {
    uebc_bus_e bus;
    logic [31:0] rdata;
    logic [31:0] cfg;
  } uebc_top_s;

  uebc_top_s t_q;
  uebc_top_s t_d;
  uebc_ep_s ep_st [`UEBC_NUM_EP];
  logic [`UEBC_NUM_EP-1:0] pc_clr;
  logic [`UEBC_NUM_EP-1:0] dme_wr;
  logic [`UEBC_NUM_EP-1:0] ep_overrun;
  logic [`UEBC_NUM_EP-1:0] ep_pkt;
  logic [`UEBC_NUM_EP*2-1:0] events;
  logic [`UEBC_NUM_EP*2-1:0] irq_status;
  logic [`UEBC_NUM_EP*2-1:0] irq_mask;
  logic wr_take;
  logic rd_take;
  logic [3:0] word;
  logic clr_wr;
  logic mask_wr;

  // =====================================================================
  // Bus decode
  // Every access answers one cycle after it is seen, so waitrequest is
  // high in the first cycle and low in the second.
  assign wr_take = avs_req.write && (t_q.bus == UEBC_BUS_ACK);
  assign rd_take = avs_req.read && (t_q.bus == UEBC_BUS_ACK);
  assign word = avs_req.address[5:2];
  assign avs_waitrequest = (avs_req.read || avs_req.write) && (t_q.bus != UEBC_BUS_ACK);
  assign avs_readdata = t_q.rdata;
  assign clr_wr = wr_take && (avs_req.address == `UEBC_OFF_IRQ_STAT);
  assign mask_wr = wr_take && (avs_req.address == `UEBC_OFF_IRQ_MASK);

  // =====================================================================
  // Endpoint counters
  for (genvar g = 0; g < `UEBC_NUM_EP; g++) begin : g_ep
    logic csr_hit;
    assign csr_hit = wr_take &&
      (avs_req.address == (`UEBC_OFF_CSR_BASE + 8'(g * 4)));
    // Packet-complete is write-one-to-clear.
    assign pc_clr[g] = csr_hit && avs_req.writedata[`UEBC_CSR_PC];
    assign dme_wr[g] = csr_hit;
    uebc_ep_counter u_ep (
      .clk(clk),
      .reset_n(reset_n),
      .is_in(t_q.cfg[g*`UEBC_CFG_NIB + `UEBC_CFG_DIR_IN] && (g != 0)),
      .dbuf(t_q.cfg[g*`UEBC_CFG_NIB + `UEBC_CFG_DBUF]),
      .pkt_in(rx_pkt.valid && (rx_pkt.ep == `UEBC_EP_IDX_W'(g))),
      .pkt_len(rx_pkt.len),
      .fifo_rd(fifo_rd && (fifo_rd_ep == `UEBC_EP_IDX_W'(g))),
      .pc_clr(pc_clr[g]),
      .dme_wr(dme_wr[g]),
      .dme_val(avs_req.writedata[`UEBC_CSR_DME]),
      .st(ep_st[g]),
      .fifo_service(fifo_service[g]),
      .overrun(ep_overrun[g]),
      .pkt_event(ep_pkt[g])
    );
    // Low half: packet events; high half: reads past empty.
    assign events[g] = ep_pkt[g];
    assign events[g + `UEBC_NUM_EP] = ep_overrun[g];
  end

  // =====================================================================
  // Interrupt status and mask
  uebc_irq u_irq (
    .clk(clk),
    .reset_n(reset_n),
    .events(events),
    .clr_wr(clr_wr),
    .mask_wr(mask_wr),
    .wdata(avs_req.writedata),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  // =====================================================================
  // Register file and read mux
  always_comb begin
    t_d = t_q;
    if (avs_req.read || avs_req.write) begin
      t_d.bus = (t_q.bus == UEBC_BUS_ACK) ? UEBC_BUS_IDLE : UEBC_BUS_ACK;
    end else begin
      t_d.bus = UEBC_BUS_IDLE;
    end
    if (wr_take && avs_req.address == `UEBC_OFF_CFG) begin
      t_d.cfg = avs_req.writedata;
    end
    t_d.rdata = `UEBC_RESET_WORD;
    if (avs_req.read && t_q.bus != UEBC_BUS_ACK) begin
      case (word)
        4'h0, 4'h1, 4'h2, 4'h3: begin
          // In endpoints hold no count; they read as zero.
          if (!(t_q.cfg[word[1:0]*`UEBC_CFG_NIB + `UEBC_CFG_DIR_IN] &&
              word[1:0] != 2'h0)) begin
            t_d.rdata[`UEBC_CNT_W-1:0] = ep_st[word[1:0]].count;
          end
          // A Setup queued behind a drained Status packet on the control
          // endpoint shows its length before software clears out-complete.
          if (word[1:0] == 2'h0 && ep_st[0].count == '0 && ep_st[0].pend.full) begin
            t_d.rdata[`UEBC_CNT_W-1:0] = ep_st[0].pend.len;
          end
        end
        4'h4, 4'h5, 4'h6, 4'h7: begin
          t_d.rdata[`UEBC_CSR_FS] = fifo_service[word[1:0]];
          t_d.rdata[`UEBC_CSR_PC] = ep_st[word[1:0]].pc;
          t_d.rdata[`UEBC_CSR_DME] = ep_st[word[1:0]].dma_enable;
          t_d.rdata[`UEBC_CSR_BNE] = ep_st[word[1:0]].bne;
        end
        4'h8: begin
          t_d.rdata = t_q.cfg;
        end
        4'h9: begin
          t_d.rdata[`UEBC_NUM_EP*2-1:0] = irq_status;
        end
        4'hA: begin
          t_d.rdata[`UEBC_NUM_EP*2-1:0] = irq_mask;
        end
        default: begin
          t_d.rdata = `UEBC_RESET_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      t_q <= '{bus: UEBC_BUS_IDLE, rdata: 32'h0000_0000, cfg: 32'h0000_0000};
    end else begin
      t_q <= t_d;
    end
  end
endmodule

//--- dv/uebc_host.sv
// Host-side model that hands whole Out and Setup packets to the block.
`timescale 1ns/1ps
module uebc_host (
  input wire logic clk,
  output uebc_pkg::uebc_pkt_s pkt
);
  import uebc_pkg::*;
  initial pkt = '0;
  // ==========
  // One packet per call as a single-cycle pulse; payload bytes are not modelled.
  // The model never sets dma_enable, so software always relies on the counts.
  task automatic send(input logic [1:0] ep, input logic [9:0] len);
    @(posedge clk);
    pkt <= '{1'b1, ep, len};
    @(posedge clk);
    pkt <= '0;
  endtask
endmodule

//--- dv/uebc_chk.sv
// Assertions on the ports of the byte-count block.
`timescale 1ns/1ps
`include "uebc_consts.svh"
module uebc_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire uebc_pkg::uebc_avm_req_s avs_req,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire uebc_pkg::uebc_pkt_s rx_pkt,
  input wire logic fifo_rd,
  input wire logic [`UEBC_EP_IDX_W-1:0] fifo_rd_ep,
  input wire logic [`UEBC_NUM_EP-1:0] fifo_service,
  input wire logic irq
);
  import uebc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic req;
  logic [3:0] rd_q;
  logic ev_q;
  assign req = avs_req.read | avs_req.write;
  // ==========
  // Remember last cycle's reads and the inputs that may set a flag.
  always_ff @(posedge clk) begin
    rd_q <= fifo_rd ? 4'h1 << fifo_rd_ep : 4'h0;
    ev_q <= rx_pkt.valid | fifo_rd | (req & ~avs_waitrequest);
  end
  // ==========
  // Bus timing: one wait cycle exactly, data only in the answer cycle.
  wait_one_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("access waited more than one cycle");
  first_wait_a: assert property ($rose(req) |-> avs_waitrequest)
    else $error("access answered without a wait cycle");
  idle_ready_a: assert property (!req |-> !avs_waitrequest)
    else $error("wait raised with no access");
  rdata_zero_a: assert property (!(avs_req.read && !avs_waitrequest)
    |-> avs_readdata == 32'h0)
    else $error("read data outside the answer cycle");
  // Flags follow packets, FIFO reads and register accesses only.
  pkt_svc_a: assert property (rx_pkt.valid && rx_pkt.ep == 2'h0 && rx_pkt.len != 10'h000
    |=> fifo_service[0])
    else $error("packet did not raise fifo service");
  svc_fall_a: assert property (((($past(fifo_service) & ~fifo_service) & ~rd_q) == 4'h0))
    else $error("fifo service dropped without a read");
  svc_rise_a: assert property ((fifo_service & ~$past(fifo_service)) != 4'h0 |-> ev_q)
    else $error("fifo service rose with no cause");
  irq_cause_a: assert property ($rose(irq) |-> ev_q)
    else $error("interrupt rose with no cause");
endmodule
bind uebc_top uebc_chk chk (.clk, .reset_n, .avs_req, .avs_waitrequest, .avs_readdata,
  .rx_pkt, .fifo_rd, .fifo_rd_ep, .fifo_service, .irq);

//--- dv/uebc_tb.sv
// Self-checking bench for the endpoint byte-count block.
`timescale 1ns/1ps
module testbench;
  import uebc_pkg::*;
  logic clk = 0;
  logic reset_n = 0;
  logic fifo_rd = 0;
  logic [1:0] fifo_rd_ep = 0;
  logic irq, avs_waitrequest;
  logic [3:0] fifo_service;
  logic [31:0] rdata;
  uebc_avm_req_s req = '0;
  uebc_pkt_s pkt;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  uebc_top dut (.clk, .reset_n, .avs_req(req), .avs_waitrequest, .avs_readdata(rdata),
    .rx_pkt(pkt), .fifo_rd, .fifo_rd_ep, .fifo_service, .irq);
  uebc_host host (.clk, .pkt);
  // ==========
  // Clock and a run limit well above the couple of hundred cycles the tests need.
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end
  // ==========
  // Shared helpers.
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Values read right after an edge are the pre-edge ones, so no race.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge clk);
    req <= '{~w, w, a, d};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = rdata;
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask
  task automatic pop(input logic [1:0] ep, input int n);
    repeat (n) begin
      @(posedge clk);
      fifo_rd <= 1'b1;
      fifo_rd_ep <= ep;
      @(posedge clk);
      fifo_rd <= 1'b0;
    end
  endtask
  // ==========
  // Scenarios.
  task automatic t_reset;
    for (int a = 0; a < 64; a += 4) rc("reset", 8'(a), 32'h0);
    wr(8'h3C, 32'hFFFF_FFFF);
    rc("unmapped", 8'h3C, 32'h0);
  endtask
  task automatic t_single;
    host.send(2'h1, 10'h00A);
    rc("cnt1", 8'h04, 32'hA);
    rc("csr1", 8'h14, 32'h43);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    wr(8'h14, 32'h8);
    rc("csr1_dme", 8'h14, 32'h4B);
    wr(8'h28, 32'hFF);
    rc("mask", 8'h28, 32'hFF);
    chk("irq_on", {31'h0, irq}, 32'h1);
    pop(2'h1, 2);
    rc("cnt1", 8'h04, 32'h2);
    pop(2'h1, 1);
    rc("cnt1", 8'h04, 32'h0);
    rc("csr1", 8'h14, 32'h0A);
    chk("svc", {28'h0, fifo_service}, 32'h0);
    pop(2'h1, 1);
    rc("irq_stat", 8'h24, 32'h22);
    wr(8'h24, 32'h22);
    rc("irq_stat", 8'h24, 32'h0);
    chk("irq_off", {31'h0, irq}, 32'h0);
  endtask
  task automatic t_dbuf;
    wr(8'h20, 32'h2100);
    host.send(2'h3, 10'h008);
    host.send(2'h3, 10'h004);
    host.send(2'h2, 10'h008);
    rc("cnt2_in", 8'h08, 32'h0);
    rc("cnt3", 8'h0C, 32'h8);
    rc("csr3", 8'h1C, 32'h3);
    pop(2'h3, 2);
    rc("cnt3", 8'h0C, 32'h0);
    chk("svc3", {31'h0, fifo_service[3]}, 32'h1);
    pop(2'h3, 1);
    rc("cnt3", 8'h0C, 32'h0);
    wr(8'h1C, 32'h2);
    rc("cnt3", 8'h0C, 32'h4);
    rc("csr3", 8'h1C, 32'h43);
    pop(2'h3, 1);
    rc("cnt3", 8'h0C, 32'h0);
    chk("svc3", {31'h0, fifo_service[3]}, 32'h0);
  endtask
  // A Status packet with a Setup behind it, then out-complete cleared.
  task automatic t_ctrl;
    host.send(2'h0, 10'h000);
    host.send(2'h0, 10'h008);
    rc("cnt0", 8'h00, 32'h8);
    chk("svc0", {31'h0, fifo_service[0]}, 32'h1);
    wr(8'h10, 32'h2);
    rc("cnt0_setup", 8'h00, 32'h8);
    rc("csr0", 8'h10, 32'h43);
  endtask
  task automatic results;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========
  // Main sequence.
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_single();
    t_dbuf();
    t_ctrl();
    results();
  end
endmodule
